//--- shared/esel_pkg.sv
// Constants and types shared by the event selector design
package esel_pkg;

  localparam int          DATA_W            = 32;
  localparam int          NUM_CHANNELS      = 16;
  localparam int          SEL_W             = 6;
  localparam int          FIELDS_PER_REG    = 4;
  localparam int          FIELD_STRIDE      = 8;
  localparam int          CHAIN_FIRST       = 8;
  localparam int          CHAIN_LAST        = 11;
  localparam int          NUM_CHAIN         = 4;

  // Byte addresses of the registers
  localparam logic [31:0] ADDR_SEL_CH0_3    = 32'h01A0_FF00;
  localparam logic [31:0] ADDR_SEL_CH4_7    = 32'h01A0_FF04;
  localparam logic [31:0] ADDR_SEL_CH12_15  = 32'h01A0_FF0C;
  localparam logic [31:0] ADDR_TRIG_SEEN    = 32'h01A0_FF10;

  // Selector fields at 5:0, 13:8, 21:16, 29:24; gaps read zero
  localparam logic [31:0] SEL_FIELD_MASK    = 32'h3F3F_3F3F;
  localparam logic [31:0] RST_SEL_CH0_3     = 32'h0302_0100;
  localparam logic [31:0] RST_SEL_CH4_7     = 32'h0706_0504;
  localparam logic [31:0] RST_SEL_CH12_15   = 32'h0F0E_0D0C;
  localparam logic [15:0] RST_TRIG_SEEN     = 16'h0000;

  // Selector codes
  localparam logic [5:0]  CODE_HOST         = 6'h00;
  localparam logic [5:0]  CODE_TIMER0       = 6'h01;
  localparam logic [5:0]  CODE_TIMER1       = 6'h02;
  localparam logic [5:0]  CODE_SDRAM        = 6'h03;
  localparam logic [5:0]  CODE_GPIO4        = 6'h04;
  localparam logic [5:0]  CODE_GPIO2        = 6'h0A;
  localparam logic [5:0]  CODE_SER0_TX      = 6'h0C;
  localparam logic [5:0]  CODE_SER1_RX      = 6'h0F;
  localparam logic [5:0]  CODE_LIMIT        = 6'h10;
  // Codes 8, 9 and 11 have no source
  localparam logic [15:0] VALID_CODE_MASK   = 16'hF4FF;

  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  typedef struct packed {
    logic host_port_to_core_event;
    logic timer0_event;
    logic timer1_event;
    logic sdram_refresh_timer_event;
    logic gpio_pin4_event;
    logic gpio_pin5_event;
    logic gpio_pin6_event;
    logic gpio_pin7_event;
    logic gpio_pin2_event;
    logic serial0_transmit_event;
    logic serial0_receive_event;
    logic serial1_transmit_event;
    logic serial1_receive_event;
  } esel_events_t;

endpackage : esel_pkg

//--- src/esel_sel_reg.sv
// One selector register with byte strobes and read-zero gaps
module esel_sel_reg
  import esel_pkg::*;
#(
  parameter logic [31:0] RESET_VALUE = 32'h0000_0000
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              wr_en,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  output logic      [DATA_W-1:0] value
);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value <= RESET_VALUE & SEL_FIELD_MASK;
    end else if (wr_en) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb[b]) begin
          // Gap bits never store, so they always read zero
          value[b*8 +: 8] <= wdata[b*8 +: 8] & SEL_FIELD_MASK[b*8 +: 8];
        end
      end
    end
  end

endmodule : esel_sel_reg

//--- src/esel_event_mux.sv
// Routes the event named by one selector code to one channel
module esel_event_mux
  import esel_pkg::*;
(
  input  wire logic [SEL_W-1:0]        code,
  input  wire logic [NUM_CHANNELS-1:0] events,
  output logic                         hit
);

  logic [NUM_CHANNELS-1:0] live_events;

  assign live_events = events & VALID_CODE_MASK;
  // Codes from 0x10 upward and the holes below select nothing
  assign hit = (code < CODE_LIMIT) ? live_events[code[3:0]] : 1'b0;

endmodule : esel_event_mux

//--- src/esel_top.sv
// Event-to-channel selector with AXI4-Lite register access
//
// The AXI4-Lite register port was decided locally.
module esel_top
  import esel_pkg::*;
(
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [31:0]             awaddr,
  input  wire logic [2:0]              awprot,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [DATA_W-1:0]       wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  input  wire logic [31:0]             araddr,
  input  wire logic [2:0]              arprot,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [DATA_W-1:0]            rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  input  wire esel_events_t            events,
  input  wire logic [NUM_CHAIN-1:0]    chain_completion_code_8,
  output logic [NUM_CHANNELS-1:0]      channel_trigger
);

  logic [31:0]             aw_addr_q;
  logic [DATA_W-1:0]       w_data_q;
  logic [3:0]              w_strb_q;
  logic                    wr_fire;
  logic                    wr_sel0;
  logic                    wr_sel1;
  logic                    wr_sel3;
  logic                    wr_seen;
  logic [DATA_W-1:0]       sel_ch0_3;
  logic [DATA_W-1:0]       sel_ch4_7;
  logic [DATA_W-1:0]       sel_ch12_15;
  logic [DATA_W-1:0]       sel_word [FIELDS_PER_REG];
  logic [NUM_CHANNELS-1:0] event_vec;
  logic [NUM_CHANNELS-1:0] next_trigger;
  logic [NUM_CHANNELS-1:0] trigger_seen;
  logic [NUM_CHANNELS-1:0] seen_clear;
  logic [DATA_W-1:0]       next_rdata;
  logic [1:0]              next_rresp;

  function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] reg_addr);
    addr_hit = (a[31:2] == reg_addr[31:2]);
  endfunction : addr_hit

  // Write channel: address and data held independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b1;
      aw_addr_q <= 32'h0000_0000;
    end else if (awvalid && awready) begin
      awready   <= 1'b0;
      aw_addr_q <= awaddr;
    end else if (wr_fire) begin
      awready   <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready   <= 1'b1;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (wvalid && wready) begin
      wready   <= 1'b0;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (wr_fire) begin
      wready   <= 1'b1;
    end
  end

  // Commit once both halves are held and the previous response is gone
  assign wr_fire = !awready && !wready && !bvalid;
  assign wr_sel0 = wr_fire && addr_hit(aw_addr_q, ADDR_SEL_CH0_3);
  assign wr_sel1 = wr_fire && addr_hit(aw_addr_q, ADDR_SEL_CH4_7);
  assign wr_sel3 = wr_fire && addr_hit(aw_addr_q, ADDR_SEL_CH12_15);
  assign wr_seen = wr_fire && addr_hit(aw_addr_q, ADDR_TRIG_SEEN);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= (wr_sel0 || wr_sel1 || wr_sel3 || wr_seen) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  esel_sel_reg #(
    .RESET_VALUE (RST_SEL_CH0_3)
  ) u_sel_ch0_3 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_sel0),
    .wdata   (w_data_q),
    .wstrb   (w_strb_q),
    .value   (sel_ch0_3)
  );

  esel_sel_reg #(
    .RESET_VALUE (RST_SEL_CH4_7)
  ) u_sel_ch4_7 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_sel1),
    .wdata   (w_data_q),
    .wstrb   (w_strb_q),
    .value   (sel_ch4_7)
  );

  esel_sel_reg #(
    .RESET_VALUE (RST_SEL_CH12_15)
  ) u_sel_ch12_15 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_sel3),
    .wdata   (w_data_q),
    .wstrb   (w_strb_q),
    .value   (sel_ch12_15)
  );

  // Word 2 would cover the chaining channels; it has no storage
  assign sel_word[0] = sel_ch0_3;
  assign sel_word[1] = sel_ch4_7;
  assign sel_word[2] = 32'h0000_0000;
  assign sel_word[3] = sel_ch12_15;

  // Event vector indexed by selector code
  assign event_vec = {
    events.serial1_receive_event,
    events.serial1_transmit_event,
    events.serial0_receive_event,
    events.serial0_transmit_event,
    1'b0,
    events.gpio_pin2_event,
    1'b0,
    1'b0,
    events.gpio_pin7_event,
    events.gpio_pin6_event,
    events.gpio_pin5_event,
    events.gpio_pin4_event,
    events.sdram_refresh_timer_event,
    events.timer1_event,
    events.timer0_event,
    events.host_port_to_core_event
  };

  // One router per channel; chaining channels bypass the selector
  for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
    if (ch >= CHAIN_FIRST && ch <= CHAIN_LAST) begin : g_chain
      assign next_trigger[ch] = chain_completion_code_8[ch - CHAIN_FIRST];
    end else begin : g_route
      esel_event_mux u_mux (
        .code   (sel_word[ch / FIELDS_PER_REG][(ch % FIELDS_PER_REG) * FIELD_STRIDE +: SEL_W]),
        .events (event_vec),
        .hit    (next_trigger[ch])
      );
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_trigger <= 16'h0000;
    end else begin
      channel_trigger <= next_trigger;
    end
  end

  // Sticky record of triggers; a new trigger beats a same-cycle clear
  assign seen_clear = wr_seen ? w_data_q[NUM_CHANNELS-1:0] : 16'h0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trigger_seen <= RST_TRIG_SEEN;
    end else begin
      trigger_seen <= (trigger_seen & ~seen_clear) | channel_trigger;
    end
  end

  // Read channel
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp = RESP_OKAY;
    if (addr_hit(araddr, ADDR_SEL_CH0_3)) begin
      next_rdata = sel_ch0_3;
    end else if (addr_hit(araddr, ADDR_SEL_CH4_7)) begin
      next_rdata = sel_ch4_7;
    end else if (addr_hit(araddr, ADDR_SEL_CH12_15)) begin
      next_rdata = sel_ch12_15;
    end else if (addr_hit(araddr, ADDR_TRIG_SEEN)) begin
      next_rdata = {16'h0000, trigger_seen};
    end else begin
      next_rresp = RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
    end
  end

endmodule : esel_top

//--- tb/esel_event_src.sv
// Model of the peripheral event sources feeding the selector
module esel_event_src
  import esel_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         pulse_en,
  input  wire logic [3:0]   pulse_sel,
  output esel_events_t      events
);
  timeunit 1ns;
  timeprecision 1ns;
  // One-cycle pulse on one source; gpio pins 4-7 sit at bits 8..5
  always_ff @(posedge aclk) begin
    if (!aresetn) events <= '0;
    else events <= pulse_en ? esel_events_t'(13'h1 << pulse_sel) : '0;
  end
endmodule : esel_event_src

//--- tb/esel_top_properties.sv
// Bus and routing properties of the selector
module esel_top_properties
  import esel_pkg::*;
(
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic                    awvalid,
  input wire logic                    awready,
  input wire logic                    wvalid,
  input wire logic                    wready,
  input wire logic                    bvalid,
  input wire logic                    bready,
  input wire logic [31:0]             araddr,
  input wire logic                    arvalid,
  input wire logic                    arready,
  input wire logic [DATA_W-1:0]       rdata,
  input wire logic [1:0]              rresp,
  input wire logic                    rvalid,
  input wire logic                    rready,
  input wire esel_events_t            events,
  input wire logic [NUM_CHAIN-1:0]    chain_completion_code_8,
  input wire logic [NUM_CHANNELS-1:0] channel_trigger
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_commit;
    !awready && !wready ##1 bvalid && awready && wready;
  endsequence
  sequence s_ar;
    arvalid && arready;
  endsequence
  AST_CHAIN_PASS: assert property (1 |=> channel_trigger[11:8] == $past(chain_completion_code_8))
    else $error("chaining channel trigger mismatch");
  AST_NO_SPURIOUS: assert property ((|channel_trigger[7:0] || |channel_trigger[15:12]) |-> $past(events) != '0)
    else $error("trigger without any source event");
  AST_WRITE_RESP: assert property (s_wr |=> s_commit)
    else $error("write response not on time");
  AST_B_DONE: assert property (bvalid && bready |=> !bvalid)
    else $error("write response not cleared");
  AST_READ_LAT: assert property (s_ar |=> rvalid && !arready)
    else $error("read answer late");
  AST_R_DONE: assert property (rvalid && rready |=> !rvalid && arready)
    else $error("read answer not cleared");
  AST_GAP_ZERO: assert property (rvalid |-> rdata[31:30] == 2'h0 && rdata[23:22] == 2'h0)
    else $error("gap bits not zero");
  AST_UNMAPPED: assert property ((s_ar and {araddr[31:2], 2'h0} == 32'h01A0_FF08)
    |=> rresp == RESP_SLVERR && rdata == '0)
    else $error("hole address answered");
endmodule : esel_top_properties

bind esel_top esel_top_properties u_props (.*);

//--- tb/esel_top_bench.sv
// Self-checking bench for the event selector
module esel_top_bench
  import esel_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic         aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic         arvalid, arready, rvalid, rready, pulse_en;
  logic [31:0]  awaddr, wdata, araddr, rdata, got;
  logic [2:0]   awprot, arprot;
  logic [3:0]   wstrb, chain_completion_code_8, pulse_sel;
  logic [1:0]   bresp, rresp, rs;
  logic [15:0]  channel_trigger;
  esel_events_t events;
  int           failures, tests_run, cycles;
  logic [31:0]  addrs [3] = '{ADDR_SEL_CH0_3, ADDR_SEL_CH4_7, ADDR_SEL_CH12_15};
  logic [31:0]  rstv [3] = '{RST_SEL_CH0_3, RST_SEL_CH4_7, RST_SEL_CH12_15};

  esel_top u_dut (.*);
  esel_event_src u_src (.*);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    if (failures == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bit ad = 0;
    bit wd = 0;
    @(posedge aclk);
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= 3'h7;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready === 1'b1) begin
        awvalid <= 1'b0;
        ad = 1;
      end
      if (!wd && wready === 1'b1) begin
        wvalid <= 1'b0;
        wd = 1;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    {got, rs} = {rdata, rresp};
    rready <= 1'b0;
  endtask : rd
  task automatic pulse(input int b);
    @(posedge aclk);
    {pulse_en, pulse_sel} <= {1'b1, 4'(b)};
    @(posedge aclk);
    pulse_en <= 1'b0;
    @(posedge aclk);
    @(negedge aclk);
  endtask : pulse
  function automatic int ev_of(input logic [5:0] c);
    if (c < 8) return 12 - int'(c);
    if (c == 6'h0A) return 4;
    if (c >= 12 && c < 16) return 15 - int'(c);
    return -1;
  endfunction : ev_of

  task automatic t_reset();
    for (int i = 0; i < 3; i++) begin
      rd(addrs[i]);
      check(got, rstv[i]);
      check(32'(rs), 32'(RESP_OKAY));
    end
    rd(32'h01A0_FF08);
    check({got[31:2], rs}, 32'(RESP_SLVERR));
    wr(32'h01A0_FF08, 32'hFFFF_FFFF);
    check(32'(rs), 32'(RESP_SLVERR));
  endtask : t_reset
  task automatic t_gaps();
    for (int i = 0; i < 3; i++) begin
      wr(addrs[i], 32'hFFFF_FFFF);
      rd(addrs[i]);
      check(got, 32'h3F3F_3F3F);
      wr(addrs[i], rstv[i]);
    end
    // Only byte 0 enabled: the other fields keep their reset codes
    wstrb <= 4'h1;
    wr(ADDR_SEL_CH4_7, 32'hFFFF_FF3F);
    wstrb <= 4'hF;
    rd(ADDR_SEL_CH4_7);
    check(got, 32'h0706_053F);
    wr(ADDR_SEL_CH4_7, RST_SEL_CH4_7);
  endtask : t_gaps
  task automatic t_codes();
    logic [5:0] c;
    for (int k = 0; k < 18; k++) begin
      c = (k < 16) ? 6'(k) : (k == 16 ? 6'h10 : 6'h3F);
      wr(ADDR_SEL_CH0_3, {RST_SEL_CH0_3[31:8], 2'h0, c});
      for (int b = 0; b < 13; b++) begin
        pulse(b);
        check(32'(channel_trigger[0]), 32'(b == ev_of(c)));
      end
    end
    wr(ADDR_SEL_CH0_3, RST_SEL_CH0_3);
  endtask : t_codes
  task automatic t_ch15();
    // Start the sticky trigger record from a clean slate
    wr(ADDR_TRIG_SEEN, 32'h0000_FFFF);
    wr(ADDR_SEL_CH12_15, 32'h010E_0D0C);
    pulse(11);
    check(32'(channel_trigger), 32'h0000_8002);
    @(posedge aclk);
    chain_completion_code_8 <= 4'hA;
    @(posedge aclk);
    chain_completion_code_8 <= 4'h0;
    @(negedge aclk);
    check(32'(channel_trigger), 32'h0000_0A00);
    rd(ADDR_TRIG_SEEN);
    check(got, 32'h0000_8A02);
    wr(ADDR_TRIG_SEEN, 32'h0000_0002);
    rd(ADDR_TRIG_SEEN);
    check(got, 32'h0000_8A00);
  endtask : t_ch15

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // Generous ceiling: the whole sequence needs about 900 cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, pulse_en} = '0;
    {awaddr, wdata, araddr, awprot, arprot, pulse_sel} = '0;
    chain_completion_code_8 = '0;
    wstrb = 4'hF;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_gaps();
    t_codes();
    t_ch15();
    give_verdict();
  end
endmodule : esel_top_bench
